/* File: hdl/nfc_pkg.sv */
// Purpose: shared constants for the nand host controller
// Assumes: 20 MHz clk, 32-bit register port with 8-bit byte addresses
// Notes: row address is page, plane and block packed low to high
package nfc_pkg;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00; // w: start op, r: status
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_COL = 8'h0c;
    localparam logic [7:0] REG_ROW = 8'h10;
    localparam logic [7:0] REG_DATA = 8'h14;
    localparam logic [7:0] REG_ID0 = 8'h18;
    localparam logic [7:0] REG_ID1 = 8'h1c;
    // field positions
    localparam int CFG_WP_RELEASE = 0;
    localparam int CFG_CE_HOLD = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_READY = 1;
    localparam int ST_PEND_LO = 2;
    localparam int ST_ID_MODE = 4;
    localparam int ROW_DIE_BIT = 18; // top block bit selects the die
    // reset values
    localparam logic [1:0] CFG_RESET = 2'h0; // write protected, ce released
    // operation codes
    localparam logic [2:0] OP_CMD = 3'h1;
    localparam logic [2:0] OP_ADDR = 3'h2;
    localparam logic [2:0] OP_IDENTIFICATION_MODE = 3'h3;
    localparam logic [2:0] OP_READ = 3'h4;
    localparam logic [2:0] OP_WRITE = 3'h5;
    // command bytes
    localparam logic [7:0] CMD_DUMMY = 8'h00;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_IDENTIFICATION_MODE = 8'h90;
    localparam logic [7:0] ADDR_ID = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    // geometry and cycle counts
    localparam int COL_W = 12;
    localparam int ROW_W = 19;
    localparam int ID_BYTES = 5;
    localparam int ADDR_CYCLES = 5;
    localparam int STROBE_NS = 150; // least strobe low time, covers pin sync
    localparam int CLK_NS = 50;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = 1; // strobe high phase closing each byte cycle
    // byte cycle kinds
    typedef enum logic [1:0] {KIND_CMD, KIND_ADDR, KIND_WRITE, KIND_READ} nfc_kind_type;
endpackage : nfc_pkg

/* File: hdl/nfc_cycle.sv */
// Purpose: one bus byte cycle on the multiplexed nand pins
// Assumes: io_in_s already synchronised to clk
// Notes: strobe low phase, then high phase; read byte sampled at end of low
`timescale 1ns/1ps
module nfc_cycle #(
    parameter int LOW_CYC = nfc_pkg::STROBE_CYC,
    parameter int HIGH_CYC = nfc_pkg::HOLD_CYC
) (
    input wire logic clk, // 20 MHz
    input wire logic rst_n, // async reset
    input wire logic en, // clock enable
    input wire logic start, // pulse, begin a byte cycle
    input wire nfc_pkg::nfc_kind_type kind, // cmd, addr, write or read
    input wire logic [7:0] wbyte, // byte to drive
    input wire logic [7:0] io_in_s, // synchronised bus
    output logic cle, // command latch strobe
    output logic ale, // address latch strobe
    output logic we_n, // write strobe
    output logic read_strobe_n, // read strobe
    output logic [7:0] io_out, // bus drive value
    output logic io_oe, // bus drive enable
    output logic done, // pulse at end of cycle
    output logic [7:0] rbyte // byte captured on read
);
    // refuse counts the 8-bit phase counter cannot hold
    if (LOW_CYC < 3 || HIGH_CYC < 1 || LOW_CYC > 255 || HIGH_CYC > 255) begin : g_bad_counts
        $error("nfc_cycle: strobe counts out of range");
    end
    typedef enum logic [2:0] {S_IDLE = 3'b001, S_LOW = 3'b010, S_HIGH = 3'b100} nfc_cyc_type;
    nfc_cyc_type st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic cle_r, cle_nxt, ale_r, ale_nxt, we_r, we_nxt, rs_r, rs_nxt, oe_r, oe_nxt, done_r, done_nxt;
    logic [7:0] out_r, out_nxt, rb_r, rb_nxt;

    // phase sequencer; latch strobes fall only after the write strobe rose
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        cle_nxt = cle_r;
        ale_nxt = ale_r;
        we_nxt = we_r;
        rs_nxt = rs_r;
        oe_nxt = oe_r;
        out_nxt = out_r;
        rb_nxt = rb_r;
        done_nxt = 1'b0;
        case (st_r)
            S_IDLE: begin
                if (start) begin
                    st_nxt = S_LOW;
                    cnt_nxt = 8'(LOW_CYC - 1);
                    cle_nxt = (kind == nfc_pkg::KIND_CMD);
                    ale_nxt = (kind == nfc_pkg::KIND_ADDR);
                    we_nxt = (kind == nfc_pkg::KIND_READ);
                    rs_nxt = (kind != nfc_pkg::KIND_READ);
                    oe_nxt = (kind != nfc_pkg::KIND_READ);
                    out_nxt = wbyte;
                end
            end
            S_LOW: begin
                if (cnt_r == 8'h00) begin
                    st_nxt = S_HIGH;
                    cnt_nxt = 8'(HIGH_CYC - 1);
                    we_nxt = 1'b1; // rising edge latches the byte
                    if (!rs_r) begin
                        rb_nxt = io_in_s;
                    end
                    rs_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            S_HIGH: begin
                if (cnt_r == 8'h00) begin
                    st_nxt = S_IDLE;
                    cle_nxt = 1'b0;
                    ale_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    done_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    // phase registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            cnt_r <= 8'h00;
            cle_r <= 1'b0;
            ale_r <= 1'b0;
            we_r <= 1'b1;
            rs_r <= 1'b1;
            oe_r <= 1'b0;
            out_r <= 8'h00;
            rb_r <= 8'h00;
            done_r <= 1'b0;
        end else if (en) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            cle_r <= cle_nxt;
            ale_r <= ale_nxt;
            we_r <= we_nxt;
            rs_r <= rs_nxt;
            oe_r <= oe_nxt;
            out_r <= out_nxt;
            rb_r <= rb_nxt;
            done_r <= done_nxt;
        end
    end

    assign cle = cle_r;
    assign ale = ale_r;
    assign we_n = we_r;
    assign read_strobe_n = rs_r;
    assign io_out = out_r;
    assign io_oe = oe_r;
    assign done = done_r;
    assign rbyte = rb_r;
endmodule : nfc_cycle

/* File: hdl/nfc_host.sv */
// Purpose: host controller driving a two-die nand flash over its pins
// Assumes: external pull-up on the ready/busy line, one chip select
// Notes: software starts operations through a small register port
`timescale 1ns/1ps
module nfc_host (
    input wire logic clk, // 20 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic en, // clock enable
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    output logic cle, // command latch strobe
    output logic ale, // address latch strobe
    output logic ce_n, // chip select
    output logic we_n, // write strobe
    output logic read_strobe_n, // read strobe
    output logic wp_n, // write protect
    output logic [7:0] io_bus_out, // bus drive value
    output logic io_bus_oe, // bus drive enable
    input wire logic [7:0] io_bus_in, // bus pin level
    input wire logic rb_n // ready/busy pin, pulled up
);
    typedef enum logic [2:0] {M_IDLE = 3'b001, M_ISSUE = 3'b010, M_WAIT = 3'b100} nfc_main_type;
    nfc_main_type st_r, st_nxt;
    logic [2:0] op_r, op_nxt, step_r, step_nxt;
    logic [1:0] cfg_r, cfg_nxt, pend_r, pend_nxt;
    logic [7:0] cmd_r, cmd_nxt, data_r, data_nxt;
    logic [nfc_pkg::COL_W-1:0] col_r, col_nxt;
    logic [nfc_pkg::ROW_W-1:0] row_r, row_nxt;
    logic die_r, die_nxt, idm_r, idm_nxt, ce_r, ce_nxt;
    logic [7:0] id_mem [nfc_pkg::ID_BYTES];
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rb_sync_r;
    logic rb_old_r;
    logic [7:0] io_s1_r, io_s2_r;
    logic cyc_start, cyc_done, last;
    nfc_pkg::nfc_kind_type kind;
    logic [7:0] byte_out, rbyte;

    // pins from outside pass two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_sync_r <= 2'h3; // pulled-up idle level, no false ready edge
            rb_old_r <= 1'b1;
            io_s1_r <= 8'h00;
            io_s2_r <= 8'h00;
        end else if (en) begin
            rb_sync_r <= {rb_sync_r[0], rb_n};
            rb_old_r <= rb_sync_r[1];
            io_s1_r <= io_bus_in;
            io_s2_r <= io_s1_r;
        end
    end

    // byte of the current step; address bytes pack col then row
    always_comb begin
        kind = nfc_pkg::KIND_CMD;
        byte_out = 8'h00;
        last = 1'b0;
        case (op_r)
            nfc_pkg::OP_CMD: begin
                byte_out = (step_r == 3'h0) ? nfc_pkg::CMD_DUMMY : cmd_r;
                last = (step_r != 3'h0);
            end
            nfc_pkg::OP_ADDR: begin
                kind = nfc_pkg::KIND_ADDR;
                case (step_r)
                    3'h0: byte_out = col_r[7:0];
                    3'h1: byte_out = {4'h0, col_r[11:8]};
                    3'h2: byte_out = row_r[7:0];
                    3'h3: byte_out = row_r[15:8];
                    default: byte_out = {5'h00, row_r[18:16]};
                endcase
                last = (step_r == 3'(nfc_pkg::ADDR_CYCLES - 1));
            end
            nfc_pkg::OP_IDENTIFICATION_MODE: begin
                if (step_r == 3'h0) begin
                    byte_out = nfc_pkg::CMD_IDENTIFICATION_MODE;
                end else if (step_r == 3'h1) begin
                    kind = nfc_pkg::KIND_ADDR;
                    byte_out = nfc_pkg::ADDR_ID;
                end else begin
                    kind = nfc_pkg::KIND_READ;
                end
                last = (step_r == 3'(nfc_pkg::ID_BYTES + 1));
            end
            nfc_pkg::OP_READ: begin
                kind = nfc_pkg::KIND_READ;
                last = 1'b1;
            end
            default: begin
                kind = nfc_pkg::KIND_WRITE;
                byte_out = data_r;
                last = 1'b1;
            end
        endcase
    end

    assign cyc_start = (st_r == M_ISSUE);

    nfc_cycle u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .en(en),
        .start(cyc_start),
        .kind(kind),
        .wbyte(byte_out),
        .io_in_s(io_s2_r),
        .cle(cle),
        .ale(ale),
        .we_n(we_n),
        .read_strobe_n(read_strobe_n),
        .io_out(io_bus_out),
        .io_oe(io_bus_oe),
        .done(cyc_done),
        .rbyte(rbyte)
    );

    // sequencer and register port; writes while busy are ignored
    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        step_nxt = step_r;
        cfg_nxt = cfg_r;
        cmd_nxt = cmd_r;
        data_nxt = data_r;
        col_nxt = col_r;
        row_nxt = row_r;
        die_nxt = die_r;
        idm_nxt = idm_r;
        pend_nxt = pend_r;
        rdata_nxt = 32'h0000_0000;
        // shared busy line: any ready rise ends every pending die
        if (rb_sync_r[1] && !rb_old_r) begin
            pend_nxt = 2'h0;
        end
        if (wr && st_r == M_IDLE) begin
            case (addr)
                nfc_pkg::REG_CTRL: begin
                    if (wdata[2:0] >= nfc_pkg::OP_CMD && wdata[2:0] <= nfc_pkg::OP_WRITE) begin
                        st_nxt = M_ISSUE;
                        op_nxt = wdata[2:0];
                        // skip the dummy unless status follows identify
                        step_nxt = (wdata[2:0] == nfc_pkg::OP_CMD
                                    && !(idm_r && cmd_r == nfc_pkg::CMD_STATUS)) ? 3'h1 : 3'h0;
                    end
                end
                nfc_pkg::REG_CFG: cfg_nxt = wdata[1:0];
                nfc_pkg::REG_CMD: cmd_nxt = wdata[7:0];
                nfc_pkg::REG_COL: col_nxt = wdata[nfc_pkg::COL_W-1:0];
                nfc_pkg::REG_ROW: row_nxt = wdata[nfc_pkg::ROW_W-1:0];
                nfc_pkg::REG_DATA: data_nxt = wdata[7:0];
                default: ;
            endcase
        end
        if (st_r == M_ISSUE) begin
            st_nxt = M_WAIT;
        end
        if (st_r == M_WAIT && cyc_done) begin
            if (kind == nfc_pkg::KIND_READ && op_r == nfc_pkg::OP_READ) begin
                data_nxt = rbyte;
            end
            if (op_r == nfc_pkg::OP_ADDR) begin
                die_nxt = row_r[nfc_pkg::ROW_DIE_BIT];
            end
            if (op_r == nfc_pkg::OP_CMD && last) begin
                idm_nxt = 1'b0;
                if (cmd_r == nfc_pkg::CMD_READ_GO || cmd_r == nfc_pkg::CMD_PROG_GO
                    || cmd_r == nfc_pkg::CMD_ERASE_GO) begin
                    pend_nxt[die_r] = 1'b1;
                end
            end
            if (op_r == nfc_pkg::OP_IDENTIFICATION_MODE) begin
                idm_nxt = 1'b1;
            end
            st_nxt = last ? M_IDLE : M_ISSUE;
            step_nxt = step_r + 3'h1;
        end
        if (rd) begin
            case (addr)
                nfc_pkg::REG_CTRL: begin
                    rdata_nxt[nfc_pkg::ST_BUSY] = (st_r != M_IDLE);
                    // ready from the edge flop so pending bits are already cleared
                    rdata_nxt[nfc_pkg::ST_READY] = rb_old_r;
                    rdata_nxt[nfc_pkg::ST_PEND_LO +: 2] = pend_r;
                    rdata_nxt[nfc_pkg::ST_ID_MODE] = idm_r;
                end
                nfc_pkg::REG_CFG: rdata_nxt[1:0] = cfg_r;
                nfc_pkg::REG_CMD: rdata_nxt[7:0] = cmd_r;
                nfc_pkg::REG_COL: rdata_nxt[nfc_pkg::COL_W-1:0] = col_r;
                nfc_pkg::REG_ROW: rdata_nxt[nfc_pkg::ROW_W-1:0] = row_r;
                nfc_pkg::REG_DATA: rdata_nxt[7:0] = data_r;
                nfc_pkg::REG_ID0: rdata_nxt = {id_mem[3], id_mem[2], id_mem[1], id_mem[0]};
                nfc_pkg::REG_ID1: rdata_nxt[7:0] = id_mem[4];
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // select held through every byte of an operation
        ce_nxt = (st_nxt != M_IDLE) || cfg_nxt[nfc_pkg::CFG_CE_HOLD];
    end

    // controller state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= M_IDLE;
            op_r <= 3'h0;
            step_r <= 3'h0;
            cfg_r <= nfc_pkg::CFG_RESET;
            cmd_r <= 8'h00;
            data_r <= 8'h00;
            col_r <= '0;
            row_r <= '0;
            die_r <= 1'b0;
            idm_r <= 1'b0;
            pend_r <= 2'h0;
            ce_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (en) begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            step_r <= step_nxt;
            cfg_r <= cfg_nxt;
            cmd_r <= cmd_nxt;
            data_r <= data_nxt;
            col_r <= col_nxt;
            row_r <= row_nxt;
            die_r <= die_nxt;
            idm_r <= idm_nxt;
            pend_r <= pend_nxt;
            ce_r <= ce_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // identification bytes, one entry per read step
    generate
        for (genvar i = 0; i < nfc_pkg::ID_BYTES; i++) begin : g_id
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    id_mem[i] <= 8'h00;
                end else if (en && st_r == M_WAIT && cyc_done && op_r == nfc_pkg::OP_IDENTIFICATION_MODE
                             && step_r == 3'(i + 2)) begin
                    id_mem[i] <= rbyte;
                end
            end
        end
    endgenerate

    assign ce_n = !ce_r;
    assign wp_n = cfg_r[nfc_pkg::CFG_WP_RELEASE];
    assign rdata = rdata_r;
endmodule : nfc_host

/* File: testbench/nfc_host_chk.sv */
// Purpose: pin checks for the nand host controller
// Assumes: one clock, async active-low reset
// Notes: strobe low phase is three cycles by design choice
`timescale 1ns/1ps
module nfc_host_chk (
    input wire logic clk, // 20 MHz
    input wire logic rst_n, // async reset
    input wire logic cle, // command latch
    input wire logic ale, // address latch
    input wire logic ce_n, // chip select
    input wire logic we_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic [7:0] io_bus_out, // bus value
    input wire logic io_bus_oe // bus enable
);
    logic we_q_r;
    logic [2:0] idx_r;
    logic [7:0] cmd_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // address byte index and last command, caught at strobe rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_q_r <= 1'b1;
            idx_r <= 3'h0;
            cmd_r <= 8'h00;
        end else begin
            we_q_r <= we_n;
            if (ce_n) begin
                idx_r <= 3'h0;
            end else if (we_n && !we_q_r && cle) begin
                idx_r <= 3'h0;
                cmd_r <= io_bus_out;
            end else if (we_n && !we_q_r && ale) begin
                idx_r <= idx_r + 3'h1;
            end
        end
    end
    a_we_low_three: assert property ($fell(we_n) |-> ##1 !we_n ##1 !we_n ##1 we_n)
        else $error("write strobe low time wrong");
    a_rd_low_three: assert property ($fell(read_strobe_n) |-> ##1 !read_strobe_n
        ##1 !read_strobe_n ##1 read_strobe_n)
        else $error("read strobe low time wrong");
    a_we_drives_bus: assert property (!we_n |-> io_bus_oe && !(cle && ale))
        else $error("bus not driven under write strobe");
    a_we_rise_hold: assert property ($rose(we_n) |-> io_bus_oe && $stable(io_bus_out) && $stable({cle, ale}))
        else $error("byte changed at write strobe rise");
    a_read_float: assert property (!read_strobe_n |-> !io_bus_oe)
        else $error("host drives bus during read");
    a_strobe_select: assert property ((!we_n || !read_strobe_n) |-> !ce_n)
        else $error("strobe without chip select");
    a_addr_pad_low: assert property ((ale && !we_n) |-> (idx_r != 3'h1 || io_bus_out[7:4] == 4'h0)
        && (idx_r != 3'h4 || io_bus_out[7:3] == 5'h00))
        else $error("unused address bits not low");
    a_id_addr_zero: assert property ((ale && !we_n && cmd_r == 8'h90) |-> io_bus_out == 8'h00)
        else $error("identify address not zero");
    a_dummy_first: assert property ((cle && $fell(we_n) && io_bus_out == 8'h70) |-> cmd_r != 8'h90)
        else $error("status follows identify directly");
endmodule : nfc_host_chk
bind nfc_host nfc_host_chk nfc_host_chk_inst (.clk(clk), .rst_n(rst_n), .cle(cle), .ale(ale), .ce_n(ce_n),
    .we_n(we_n), .read_strobe_n(read_strobe_n), .io_bus_out(io_bus_out), .io_bus_oe(io_bus_oe));

/* File: testbench/nfc_flash_model.sv */
// Purpose: behavioural two-die nand flash at the pins
// Assumes: bench resolves the bus and the ready/busy pull-up
// Notes: busy time shortened; no status byte output modelled
`timescale 1ns/1ps
module nfc_flash_model #(
    parameter int BUSY_NS = 3000, // internal operation time
    parameter logic [39:0] ID_V = 40'h0 // id bytes, value arbitrary
) (
    input wire logic ce_n, // chip select
    input wire logic cle, // command latch
    input wire logic ale, // address latch
    input wire logic we_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic wp_n, // write protect
    input wire logic [7:0] io, // resolved bus
    output logic [7:0] dev_out, // byte driven
    output logic dev_oe, // drive enable
    output logic rb_low // open-drain pull-down on
);
    logic [7:0] ab [0:4];
    logic [7:0] cmd_last, cmd_prev;
    logic [11:0] col;
    logic [18:0] row;
    logic id_mode;
    int n_addr, id_idx, busy_n, bad_unused;
    function automatic logic [7:0] cell_byte(input logic [11:0] c);
        return (c < 12'h880) ? (c[7:0] ^ {c[11:8], 4'h5}) : 8'hff;
    endfunction : cell_byte
    initial begin
        {dev_out, dev_oe, id_mode, cmd_last, cmd_prev, col, row} = '0;
        {n_addr, id_idx, busy_n, bad_unused} = '0;
    end
    assign rb_low = (busy_n != 0);
    // each die runs its own operation, the shared pin shows any busy
    task automatic start_busy();
        busy_n++;
        fork
            begin
                #BUSY_NS;
                busy_n--;
            end
        join_none
    endtask : start_busy
    // command and address bytes latched on strobe rise
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            cmd_prev = cmd_last;
            cmd_last = io;
            id_mode = (io == 8'h90);
            id_idx = 0;
            n_addr = 0;
            if (io == 8'h30 || (wp_n && (io == 8'h10 || io == 8'hd0))) start_busy();
        end else if (!ce_n && ale) begin
            if (n_addr < 5) ab[n_addr] = io;
            n_addr++;
            if (n_addr == 5) begin
                if (ab[1][7:4] != 4'h0 || ab[4][7:3] != 5'h00) bad_unused++;
                col = {ab[1][3:0], ab[0]};
                row = {ab[4][2:0], ab[3], ab[2]};
            end
        end
    end
    // read strobe fall drives the next byte
    always @(negedge read_strobe_n) begin
        if (!ce_n) begin
            dev_out = id_mode ? ID_V[8 * (id_idx % 5) +: 8] : cell_byte(col);
            if (id_mode) id_idx++;
            else col++;
            dev_oe = 1'b1;
        end
    end
    always @(posedge read_strobe_n or posedge ce_n) dev_oe = 1'b0;
endmodule : nfc_flash_model

/* File: testbench/nfc_host_tb_top.sv */
// Purpose: self-checking bench for the nand host controller
// Assumes: flash model on the pins, pull-up on ready/busy
// Notes: expected values reckoned here, never read back from the design
`timescale 1ns/1ps
module nfc_host_tb_top;
    localparam logic [39:0] ID_V = 40'h27_0e_42_71_3c; // arbitrary id bytes
    logic clk, rst_n, en, wr, rd, wp_n, cle, ale, ce_n, we_n, read_strobe_n, io_bus_oe, dev_oe, rb_low, rb_n;
    logic [7:0] addr, io_bus_out, io_bus_in, dev_out, flt_r;
    logic [31:0] wdata, rdata;
    int n_mismatch = 0;
    int check_count = 0;
    // released bus toggles each cycle, pull-up holds ready high
    assign io_bus_in = io_bus_oe ? io_bus_out : (dev_oe ? dev_out : flt_r);
    assign rb_n = rb_low ? 1'b0 : 1'b1;
    always #25 clk = ~clk;
    always @(posedge clk) flt_r <= ~io_bus_in;
    nfc_host nfc_host_inst (.clk(clk), .rst_n(rst_n), .en(en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
        .io_bus_out(io_bus_out), .io_bus_oe(io_bus_oe), .io_bus_in(io_bus_in), .rb_n(rb_n));
    // busy outlasts the next operation so both dies overlap
    nfc_flash_model #(.ID_V(ID_V), .BUSY_NS(6000)) nfc_flash_model_inst (.ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io(io_bus_in), .dev_out(dev_out),
        .dev_oe(dev_oe), .rb_low(rb_low));
    function automatic logic [7:0] exp_byte(input logic [11:0] c);
        return c[7:0] ^ {c[11:8], 4'h5};
    endfunction : exp_byte
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : reg_rd
    // bounded poll of one status bit
    task automatic poll(input int b, input logic v, output logic [31:0] s);
        int n;
        n = 0;
        do begin
            reg_rd(nfc_pkg::REG_CTRL, s);
            n++;
        end while (s[b] !== v && n < 200);
        chk(32'(s[b]), 32'(v), "status wait");
    endtask : poll
    task automatic run_op(input logic [2:0] op, input logic [7:0] c);
        logic [31:0] s;
        reg_wr(nfc_pkg::REG_CMD, 32'(c));
        reg_wr(nfc_pkg::REG_CTRL, 32'(op));
        poll(nfc_pkg::ST_BUSY, 1'b0, s);
    endtask : run_op
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        conclude();
    end
    initial begin
        logic [31:0] d;
        logic [11:0] col;
        logic [18:0] row;
        logic [1:0] pend;
        {clk, rst_n, wr, rd, addr, wdata, flt_r, pend} = '0;
        en = 1'b1;
        void'($urandom(32'he6c31ab0));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(nfc_pkg::REG_CFG, d);
        chk(d, 32'(nfc_pkg::CFG_RESET), "cfg reset");
        chk(32'(wp_n), 32'h0, "protect at reset");
        reg_rd(8'h40, d);
        chk(d, 32'h0, "unmapped read");
        $display("test reset done");
        // identify, then status with the dummy command in between
        reg_wr(nfc_pkg::REG_CFG, 32'h1);
        run_op(nfc_pkg::OP_IDENTIFICATION_MODE, 8'h00);
        reg_rd(nfc_pkg::REG_ID0, d);
        chk(d, ID_V[31:0], "id bytes 0-3");
        reg_rd(nfc_pkg::REG_ID1, d);
        chk(d, 32'(ID_V[39:32]), "id byte 4");
        reg_rd(nfc_pkg::REG_CTRL, d);
        chk(32'(d[nfc_pkg::ST_ID_MODE]), 32'h1, "id mode kept");
        run_op(nfc_pkg::OP_CMD, nfc_pkg::CMD_STATUS);
        chk({nfc_flash_model_inst.cmd_prev, nfc_flash_model_inst.cmd_last}, 32'h0070, "dummy first");
        reg_rd(nfc_pkg::REG_CTRL, d);
        chk(32'(d[nfc_pkg::ST_ID_MODE]), 32'h0, "id mode left");
        $display("test identify done");
        // random addresses on both dies, overlapping, then page reads
        for (int k = 0; k < 4; k++) begin
            col = 12'($urandom_range(2172, 0));
            row = 19'($urandom);
            row[18] = k[0];
            run_op(nfc_pkg::OP_CMD, nfc_pkg::CMD_DUMMY);
            reg_wr(nfc_pkg::REG_COL, 32'(col));
            reg_wr(nfc_pkg::REG_ROW, 32'(row));
            run_op(nfc_pkg::OP_ADDR, 8'h00);
            chk(32'(nfc_flash_model_inst.col), 32'(col), "column");
            chk(32'(nfc_flash_model_inst.row), 32'(row), "row");
            chk(32'(nfc_flash_model_inst.bad_unused), 32'h0, "unused bits");
            run_op(nfc_pkg::OP_CMD, nfc_pkg::CMD_READ_GO);
            pend[row[18]] = 1'b1;
            reg_rd(nfc_pkg::REG_CTRL, d);
            chk(d, {28'h0, pend, 2'b00}, "busy per die");
            if (k[0]) begin
                poll(nfc_pkg::ST_READY, 1'b1, d);
                chk(d, 32'h2, "ready, nothing pending");
                pend = 2'b00;
                for (int j = 0; j < 3; j++) begin
                    run_op(nfc_pkg::OP_READ, 8'h00);
                    reg_rd(nfc_pkg::REG_DATA, d);
                    chk(d, 32'(exp_byte(col + 12'(j))), "page byte");
                end
            end
        end
        $display("test address and read done");
        // protected program refused, erase accepted once released
        reg_wr(nfc_pkg::REG_CFG, 32'h0);
        run_op(nfc_pkg::OP_CMD, nfc_pkg::CMD_PROG_GO);
        repeat (6) @(posedge clk);
        reg_rd(nfc_pkg::REG_CTRL, d);
        chk({30'h0, d[1:0]}, 32'h2, "protected program");
        chk(32'(wp_n), 32'h0, "protect pin");
        reg_wr(nfc_pkg::REG_CFG, 32'h1);
        run_op(nfc_pkg::OP_CMD, nfc_pkg::CMD_ERASE_GO);
        reg_rd(nfc_pkg::REG_CTRL, d);
        chk({30'h0, d[1:0]}, 32'h0, "erase busy");
        poll(nfc_pkg::ST_READY, 1'b1, d);
        $display("test write protect done");
        // clock enable low: a register write is frozen out
        @(posedge clk);
        en <= 1'b0;
        reg_wr(nfc_pkg::REG_CFG, 32'h0);
        en <= 1'b1;
        reg_rd(nfc_pkg::REG_CFG, d);
        chk(d, 32'h1, "frozen write");
        $display("test clock enable done");
        conclude();
    end
endmodule : nfc_host_tb_top
